// ---- hdl/hcl_comp_lin.sv ----
// Purpose: temperature compensation and 17-point linearizer path
// Assumes: samples and temperature delta come from same-clock logic
// Notes: one sample in flight at a time; see sample_ready_o
//
// Behaviour
// - Sample scaled by polarity, coarse gain, fine gain and temperature factor.
// - Hot coefficients at or above 25 C, cold ones below it.
// - Each region uses only its own first and second order terms.
// - Delta is ambient minus 25 C; factor 1+(tc2/1000*d+tc1)*d/100.
// - Sensitivity result saturated to 17-bit signed.
// - Add fine offset plus region first-order offset times delta.
// - Compensation result saturated to 13-bit signed.
// - Polarity bit 15 of register 0x3; zero keeps positive sign.
// - Coarse gain bits 14:12, fine gain bits 10:0 of 0x3.
// - First-order gain coefficients in 0x4, hot 10:0, cold 22:12.
// - Second-order gain coefficients in 0x5, hot 9:0, cold 21:12.
// - Fine quiescent offset is 16 bits at 0x6 15:0.
// - Offset coefficients in 0x7, hot 11:0, cold 23:12.
// - Piecewise-linear transfer over 17 breakpoints, 16 segments.
// - Breakpoint inputs are 12-bit table words; outputs fixed, equally spaced.
// - Equal adjacent breakpoints jump over the skipped output interval.
// - Between breakpoints, interpolate linearly between output coordinates.
// - Below first breakpoint extrapolate from -2048/-1792, floor -2304.
// - Above last breakpoint extrapolate from 1792/2048, ceiling 2304.
// - Output 13-bit signed; interpolating and binning modes both provided.
// - Binning bit 13 of 0x12 outputs coordinate of highest breakpoint <= input.
// - Bit 12 of 0x12 enables the breakpoint table.
// - Bits 15 and 14 of 0x12 invert linearizer input and output.
//
// Our own choice: the strobed register port.

`timescale 1ns/100ps

module hcl_comp_lin #(
	parameter int SAMPLE_W = 16,
	parameter int TEMP_W = 9
) (
	input wire logic clk_sys_i, // System clock, 100 MHz
	input wire logic rst_n_i, // Async reset, active low
	input wire logic signed [SAMPLE_W-1:0] sample_i, // Front-end sample
	input wire logic signed [TEMP_W-1:0] temp_delta_i, // Ambient - 25 C
	input wire logic sample_valid_i, // Sample strobe
	output logic sample_ready_o, // Path can take a sample
	input wire logic [4:0] reg_addr_i, // Register address
	input wire logic [23:0] reg_wdata_i, // Register write data
	input wire logic reg_we_i, // Register write strobe
	input wire logic reg_re_i, // Register read strobe
	output logic [23:0] reg_rdata_o, // Read data, one cycle later
	output logic signed [12:0] comp_o, // Compensated value
	output logic comp_valid_o, // Compensated value pulse
	output logic signed [12:0] lin_o, // Linearizer output
	output logic lin_valid_o, // Linearizer output pulse
	output logic busy_o // Sample in flight
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic signed [12:0] sat13(
		input logic signed [31:0] v
	);
		if (v > 32'sd4095) begin
			sat13 = 13'sd4095;
		end else if (v < -32'sd4096) begin
			sat13 = -13'sd4096;
		end else begin
			sat13 = v[12:0];
		end
	endfunction

	function automatic logic signed [12:0] out_pol(
		input logic signed [15:0] y,
		input logic inv
	);
		logic signed [31:0] t;
		t = 32'(y);
		out_pol = inv ? sat13(-t) : sat13(t);
	endfunction

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [23:0] gain_trim;
	logic [23:0] first_order_gain_tc;
	logic [23:0] second_order_gain_tc;
	logic [23:0] quiescent_offset_trim;
	logic [23:0] offset_temp_coeff;
	logic [23:0] lin_word [hcl_pkg::LIN_WORDS];

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gain_trim <= hcl_pkg::REG_RESET;
			first_order_gain_tc <= hcl_pkg::REG_RESET;
			second_order_gain_tc <= hcl_pkg::REG_RESET;
			quiescent_offset_trim <= hcl_pkg::REG_RESET;
			offset_temp_coeff <= hcl_pkg::REG_RESET;
			for (int i = 0; i < hcl_pkg::LIN_WORDS; i++) begin
				lin_word[i] <= hcl_pkg::REG_RESET;
			end
		end else if (reg_we_i) begin
			if (reg_addr_i == hcl_pkg::ADDR_GAIN_TRIM) begin
				gain_trim <= reg_wdata_i;
			end else if (reg_addr_i == hcl_pkg::ADDR_GAIN_TC1) begin
				first_order_gain_tc <= reg_wdata_i;
			end else if (reg_addr_i == hcl_pkg::ADDR_GAIN_TC2) begin
				second_order_gain_tc <= reg_wdata_i;
			end else if (reg_addr_i == hcl_pkg::ADDR_QO_TRIM) begin
				quiescent_offset_trim <= reg_wdata_i;
			end else if (reg_addr_i == hcl_pkg::ADDR_QO_TC) begin
				offset_temp_coeff <= reg_wdata_i;
			end else if (reg_addr_i >= hcl_pkg::ADDR_LIN_FIRST &&
				reg_addr_i <= hcl_pkg::ADDR_LIN_CTRL) begin
				lin_word[4'(reg_addr_i - hcl_pkg::ADDR_LIN_FIRST)] <=
					reg_wdata_i;
			end
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= '0;
		end else if (!reg_re_i) begin
			reg_rdata_o <= '0;
		end else if (reg_addr_i == hcl_pkg::ADDR_GAIN_TRIM) begin
			reg_rdata_o <= gain_trim;
		end else if (reg_addr_i == hcl_pkg::ADDR_GAIN_TC1) begin
			reg_rdata_o <= first_order_gain_tc;
		end else if (reg_addr_i == hcl_pkg::ADDR_GAIN_TC2) begin
			reg_rdata_o <= second_order_gain_tc;
		end else if (reg_addr_i == hcl_pkg::ADDR_QO_TRIM) begin
			reg_rdata_o <= quiescent_offset_trim;
		end else if (reg_addr_i == hcl_pkg::ADDR_QO_TC) begin
			reg_rdata_o <= offset_temp_coeff;
		end else if (reg_addr_i >= hcl_pkg::ADDR_LIN_FIRST &&
			reg_addr_i <= hcl_pkg::ADDR_LIN_CTRL) begin
			reg_rdata_o <= lin_word[4'(reg_addr_i - hcl_pkg::ADDR_LIN_FIRST)];
		end else if (reg_addr_i == hcl_pkg::ADDR_STATUS) begin
			reg_rdata_o <= {7'h00, busy_o, 3'h0, comp_o};
		end else if (reg_addr_i == hcl_pkg::ADDR_RESULT) begin
			reg_rdata_o <= {11'h000, lin_o};
		end else begin
			reg_rdata_o <= '0;
		end
	end

	// ----------------------------------------------------------------
	// Field extraction
	// ----------------------------------------------------------------
	// polarity select
	logic pol;
	logic [2:0] coarse;
	logic [10:0] fine;
	logic lin_en;
	logic lin_bin;
	logic lin_out_inv;
	logic lin_in_inv;

	assign pol = gain_trim[hcl_pkg::POL_BIT];
	assign coarse = gain_trim[hcl_pkg::COARSE_MSB:hcl_pkg::COARSE_LSB];
	assign fine = gain_trim[hcl_pkg::FINE_MSB:0];
	assign lin_en = lin_word[8][hcl_pkg::LIN_EN_BIT];
	assign lin_bin = lin_word[8][hcl_pkg::LIN_BIN_BIT];
	assign lin_out_inv = lin_word[8][hcl_pkg::LIN_OUT_INV_BIT];
	assign lin_in_inv = lin_word[8][hcl_pkg::LIN_IN_INV_BIT];

	// ----------------------------------------------------------------
	// Stage 0: capture sample and delta
	// ----------------------------------------------------------------
	hcl_pkg::hcl_ln_state_t state;
	logic v0, v1, v2, v3;
	logic signed [SAMPLE_W-1:0] smp0;
	logic signed [TEMP_W-1:0] dt0, dt1, dt2;
	logic hot0, hot1, hot2;

	assign busy_o = v0 | v1 | v2 | v3 | (state == hcl_pkg::HCL_LN_DIV);
	assign sample_ready_o = !busy_o;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			v0 <= 1'b0;
			smp0 <= '0;
			dt0 <= '0;
			hot0 <= 1'b0;
		end else begin
			v0 <= sample_valid_i && sample_ready_o;
			if (sample_valid_i && sample_ready_o) begin
				smp0 <= sample_i;
				dt0 <= temp_delta_i;
				hot0 <= !temp_delta_i[TEMP_W-1];
			end
		end
	end

	// ----------------------------------------------------------------
	// Stage 1: static gain and temperature factor
	// ----------------------------------------------------------------
	logic signed [12:0] fine_q;
	logic signed [17:0] g0;
	logic [2:0] k;
	logic signed [23:0] next_g1, g1;
	logic signed [10:0] tc1_sel;
	logic signed [9:0] tc2_sel;
	logic signed [31:0] t1, t2;
	logic signed [29:0] next_fac, fac1;

	// Fine multiplier spans 0.5 .. 1.5 in Q11
	assign fine_q = {1'b0, 12'(hcl_pkg::FINE_ONE + {1'b0, fine})};

	hcl_sat_mul #(.AW(SAMPLE_W), .BW(13), .SH(hcl_pkg::FINE_FRAC),
		.OW(18)) u_fine (
		.a_i(smp0),
		.b_i(fine_q),
		.p_o(g0)
	);

	always_comb begin
		k = (coarse > hcl_pkg::COARSE_MAX) ? hcl_pkg::COARSE_MAX : coarse;
		next_g1 = 24'(g0) <<< k;
		if (pol) begin
			next_g1 = -next_g1;
		end
		// region picks its own coefficient pair
		if (hot0) begin
			tc1_sel = first_order_gain_tc[hcl_pkg::TC1_HOT_MSB:0];
			tc2_sel = second_order_gain_tc[hcl_pkg::TC2_HOT_MSB:0];
		end else begin
			tc1_sel = first_order_gain_tc[hcl_pkg::TC1_COLD_MSB:
				hcl_pkg::TC1_COLD_LSB];
			tc2_sel = second_order_gain_tc[hcl_pkg::TC2_COLD_MSB:
				hcl_pkg::TC2_COLD_LSB];
		end
		// /100 and /1000 folded into the coefficient LSB weights
		t1 = (32'(tc1_sel) * 32'(dt0)) <<< (hot0 ? hcl_pkg::TC1_SH_HOT :
			hcl_pkg::TC1_SH_COLD);
		t2 = (32'(tc2_sel) * 32'(dt0) * 32'(dt0)) <<<
			(hot0 ? hcl_pkg::TC2_SH_HOT : hcl_pkg::TC2_SH_COLD);
		next_fac = 30'(hcl_pkg::FAC_ONE + t1 + t2);
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			v1 <= 1'b0;
			g1 <= '0;
			fac1 <= '0;
			dt1 <= '0;
			hot1 <= 1'b0;
		end else begin
			v1 <= v0;
			g1 <= next_g1;
			fac1 <= next_fac;
			dt1 <= dt0;
			hot1 <= hot0;
		end
	end

	// ----------------------------------------------------------------
	// Stage 2: apply temperature factor
	// ----------------------------------------------------------------
	logic signed [16:0] y1c, y1;

	hcl_sat_mul #(.AW(24), .BW(30), .SH(hcl_pkg::FAC_FRAC),
		.OW(17)) u_temp (
		.a_i(g1),
		.b_i(fac1),
		.p_o(y1c)
	);

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			v2 <= 1'b0;
			y1 <= '0;
			dt2 <= '0;
			hot2 <= 1'b0;
		end else begin
			v2 <= v1;
			y1 <= y1c;
			dt2 <= dt1;
			hot2 <= hot1;
		end
	end

	// ----------------------------------------------------------------
	// Stage 3: offset trim
	// ----------------------------------------------------------------
	logic signed [11:0] qotc_sel;
	logic signed [15:0] qo;
	logic signed [31:0] off_t;

	assign qo = quiescent_offset_trim[hcl_pkg::QO_MSB:0];

	always_comb begin
		if (hot2) begin
			qotc_sel = offset_temp_coeff[hcl_pkg::QOTC_HOT_MSB:0];
		end else begin
			qotc_sel = offset_temp_coeff[hcl_pkg::QOTC_COLD_MSB:
				hcl_pkg::QOTC_COLD_LSB];
		end
		off_t = (32'(qotc_sel) * 32'(dt2)) >>> (hot2 ? hcl_pkg::QOTC_SH_HOT :
			hcl_pkg::QOTC_SH_COLD);
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			v3 <= 1'b0;
			comp_o <= '0;
		end else begin
			v3 <= v2;
			if (v2) begin
				// offset sum; saturate to 13 bits
				comp_o <= sat13(32'(y1) + 32'(qo) + off_t);
			end
		end
	end

	assign comp_valid_o = v3;

	// ----------------------------------------------------------------
	// Linearizer segment search
	// ----------------------------------------------------------------
	logic signed [12:0] x;
	logic signed [13:0] x14;
	logic signed [13:0] bp [hcl_pkg::BP_COUNT];
	logic [4:0] cnt;
	logic signed [13:0] lo, hi, diff;
	logic signed [15:0] base, bin_y;
	logic neg;
	logic [13:0] num, den;

	always_comb begin
		x = lin_in_inv ? sat13(-32'(comp_o)) : comp_o;
		x14 = 14'(x);
		// 12-bit programmable inputs, two per word, only one in word 8
		for (int i = 0; i < hcl_pkg::BP_COUNT; i++) begin
			if (i % 2 == 0) begin
				bp[i] = 14'(signed'(lin_word[i/2][11:0]));
			end else begin
				bp[i] = 14'(signed'(lin_word[i/2][23:hcl_pkg::BP_HI_LSB]));
			end
		end
		// count skips equal entries, so no in-between outputs
		cnt = '0;
		for (int i = 0; i < hcl_pkg::BP_COUNT; i++) begin
			if (x14 >= bp[i]) begin
				cnt = cnt + 5'd1;
			end
		end
	end

	always_comb begin
		if (cnt == 5'd0) begin
			lo = bp[0];
			hi = bp[1];
			base = hcl_pkg::Y_FIRST;
			neg = 1'b1;
		end else if (cnt == 5'(hcl_pkg::BP_COUNT)) begin
			lo = bp[15];
			hi = bp[16];
			base = hcl_pkg::Y_BEFORE_LAST;
			neg = 1'b0;
		end else begin
			lo = bp[5'(cnt - 5'd1)];
			hi = bp[cnt];
			base = 16'(hcl_pkg::Y_FIRST + hcl_pkg::Y_STEP *
				signed'({11'h000, 5'(cnt - 5'd1)}));
			neg = 1'b0;
		end
		diff = neg ? 14'(lo - x14) : 14'(x14 - lo);
		num = diff;
		den = 14'(hi - lo);
		// highest entry not above x; below all gives the floor
		bin_y = (cnt == 5'd0) ? -hcl_pkg::Y_LIMIT :
			(cnt == 5'(hcl_pkg::BP_COUNT)) ? hcl_pkg::Y_LAST : base;
	end

	// ----------------------------------------------------------------
	// Linearizer control
	// ----------------------------------------------------------------
	logic div_start, div_done;
	logic [21:0] quot;
	logic [21:0] qc;
	logic signed [15:0] base_q, yi;
	logic neg_q;
	hcl_pkg::hcl_ln_state_t next_state;
	logic signed [12:0] next_lin;
	logic next_lin_valid;

	hcl_div #(.NW(hcl_pkg::DIV_NW), .DW(hcl_pkg::DIV_DW)) u_div (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.start_i(div_start),
		.num_i({num, 8'h00}),
		.den_i(den),
		.quot_o(quot),
		.done_o(div_done)
	);

	always_comb begin
		next_state = state;
		next_lin = lin_o;
		next_lin_valid = 1'b0;
		div_start = 1'b0;
		qc = (quot > hcl_pkg::Q_MAX) ? hcl_pkg::Q_MAX : quot;
		yi = neg_q ? 16'(base_q - signed'(qc[15:0])) :
			16'(base_q + signed'(qc[15:0]));
		if (yi > hcl_pkg::Y_LIMIT) begin
			yi = hcl_pkg::Y_LIMIT;
		end else if (yi < -hcl_pkg::Y_LIMIT) begin
			yi = -hcl_pkg::Y_LIMIT;
		end
		case (state)
			hcl_pkg::HCL_LN_IDLE: begin
				if (v3) begin
					if (!lin_en) begin
						next_lin = out_pol(16'(x), lin_out_inv);
						next_lin_valid = 1'b1;
					end else if (lin_bin) begin
						next_lin = out_pol(bin_y, lin_out_inv);
						next_lin_valid = 1'b1;
					end else if (cnt == 5'(hcl_pkg::BP_COUNT) &&
						x14 == bp[16]) begin
						next_lin = out_pol(hcl_pkg::Y_LAST, lin_out_inv);
						next_lin_valid = 1'b1;
					end else if (num == '0) begin
						next_lin = out_pol(base, lin_out_inv);
						next_lin_valid = 1'b1;
					end else begin
						div_start = 1'b1;
						next_state = hcl_pkg::HCL_LN_DIV;
					end
				end
			end
			hcl_pkg::HCL_LN_DIV: begin
				if (div_done) begin
					next_lin = out_pol(yi, lin_out_inv);
					next_lin_valid = 1'b1;
					next_state = hcl_pkg::HCL_LN_IDLE;
				end
			end
			default: begin
				next_state = hcl_pkg::HCL_LN_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= hcl_pkg::HCL_LN_IDLE;
			lin_o <= '0;
			lin_valid_o <= 1'b0;
			base_q <= '0;
			neg_q <= 1'b0;
		end else begin
			state <= next_state;
			lin_o <= next_lin;
			lin_valid_o <= next_lin_valid;
			if (div_start) begin
				base_q <= base;
				neg_q <= neg;
			end
		end
	end
endmodule

// ---- hdl/hcl_div.sv ----
// Purpose: unsigned restoring divider, one quotient bit per clock
// Assumes: start_i is a one-cycle pulse while idle
// Notes: divide by zero yields all ones

`timescale 1ns/100ps

module hcl_div #(
	parameter int NW = 22,
	parameter int DW = 14
) (
	input wire logic clk_sys_i, // System clock
	input wire logic rst_n_i, // Async reset, active low
	input wire logic start_i, // Start pulse
	input wire logic [NW-1:0] num_i, // Dividend
	input wire logic [DW-1:0] den_i, // Divisor
	output logic [NW-1:0] quot_o, // Quotient
	output logic done_o // Quotient valid pulse
);
	localparam int CW = $clog2(NW + 1);

	logic [DW-1:0] rem;
	logic [DW-1:0] den_q;
	logic [NW-1:0] quo;
	logic [CW-1:0] cnt;
	logic [DW:0] trial;
	logic ge;

	always_comb begin
		trial = {rem, quo[NW-1]};
		ge = (trial >= {1'b0, den_q});
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rem <= '0;
			den_q <= '0;
			quo <= '0;
			cnt <= '0;
			done_o <= 1'b0;
		end else begin
			done_o <= (cnt == CW'(1)) && !start_i;
			if (start_i) begin
				quo <= num_i;
				rem <= '0;
				den_q <= den_i;
				cnt <= CW'(NW);
			end else if (cnt != '0) begin
				// Remainder stays below divisor, so DW bits hold it
				rem <= ge ? DW'(trial - {1'b0, den_q}) : trial[DW-1:0];
				quo <= {quo[NW-2:0], ge};
				cnt <= cnt - CW'(1);
			end
		end
	end

	assign quot_o = quo;
endmodule

// ---- hdl/hcl_pkg.sv ----
// Purpose: constants shared by the compensation and linearizer path
// Assumes: 24-bit register words, 5-bit register addresses
// Notes: all register resets are zero

package hcl_pkg;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [4:0] ADDR_GAIN_TRIM = 5'h03;
	localparam logic [4:0] ADDR_GAIN_TC1 = 5'h04;
	localparam logic [4:0] ADDR_GAIN_TC2 = 5'h05;
	localparam logic [4:0] ADDR_QO_TRIM = 5'h06;
	localparam logic [4:0] ADDR_QO_TC = 5'h07;
	localparam logic [4:0] ADDR_LIN_FIRST = 5'h0a;
	localparam logic [4:0] ADDR_LIN_CTRL = 5'h12;
	localparam logic [4:0] ADDR_STATUS = 5'h14;
	localparam logic [4:0] ADDR_RESULT = 5'h15;
	localparam int LIN_WORDS = 9;
	localparam int BP_COUNT = 17;
	localparam logic [23:0] REG_RESET = 24'h000000;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int POL_BIT = 15;
	localparam int COARSE_MSB = 14;
	localparam int COARSE_LSB = 12;
	localparam int FINE_MSB = 10;
	localparam int TC1_HOT_MSB = 10;
	localparam int TC1_COLD_MSB = 22;
	localparam int TC1_COLD_LSB = 12;
	localparam int TC2_HOT_MSB = 9;
	localparam int TC2_COLD_MSB = 21;
	localparam int TC2_COLD_LSB = 12;
	localparam int QO_MSB = 15;
	localparam int QOTC_HOT_MSB = 11;
	localparam int QOTC_COLD_MSB = 23;
	localparam int QOTC_COLD_LSB = 12;
	localparam int BP_HI_LSB = 12;
	localparam int LIN_EN_BIT = 12;
	localparam int LIN_BIN_BIT = 13;
	localparam int LIN_OUT_INV_BIT = 14;
	localparam int LIN_IN_INV_BIT = 15;
	localparam int STAT_BUSY_BIT = 16;

	// ----------------------------------------------------------------
	// Arithmetic scaling
	// ----------------------------------------------------------------
	localparam logic [11:0] FINE_ONE = 12'h400;
	localparam int FINE_FRAC = 11;
	localparam logic [2:0] COARSE_MAX = 3'h5;
	localparam int FAC_FRAC = 25;
	localparam logic signed [31:0] FAC_ONE = 32'sh02000000;
	localparam int TC1_SH_HOT = 7;
	localparam int TC1_SH_COLD = 8;
	localparam int TC2_SH_HOT = 0;
	localparam int TC2_SH_COLD = 2;
	localparam int QOTC_SH_HOT = 6;
	localparam int QOTC_SH_COLD = 5;

	// ----------------------------------------------------------------
	// Linearizer output coordinates
	// ----------------------------------------------------------------
	localparam logic signed [15:0] Y_FIRST = -16'sd2048;
	localparam logic signed [15:0] Y_STEP = 16'sd256;
	localparam logic signed [15:0] Y_BEFORE_LAST = 16'sd1792;
	localparam logic signed [15:0] Y_LAST = 16'sd2048;
	localparam logic signed [15:0] Y_LIMIT = 16'sd2304;
	localparam logic [21:0] Q_MAX = 22'h000200;
	localparam int STEP_SH = 8;
	localparam int DIV_NW = 22;
	localparam int DIV_DW = 14;

	typedef enum logic {
		HCL_LN_IDLE = 1'b0,
		HCL_LN_DIV = 1'b1
	} hcl_ln_state_t;
endpackage

// ---- hdl/hcl_sat_mul.sv ----
// Purpose: signed multiply, arithmetic right shift, saturate
// Assumes: AW + BW >= OW
// Notes: purely combinational

`timescale 1ns/100ps

module hcl_sat_mul #(
	parameter int AW = 16,
	parameter int BW = 13,
	parameter int SH = 11,
	parameter int OW = 18
) (
	input wire logic signed [AW-1:0] a_i, // Multiplicand
	input wire logic signed [BW-1:0] b_i, // Multiplier
	output logic signed [OW-1:0] p_o // Saturated scaled product
);
	localparam int PW = AW + BW;
	localparam logic signed [PW-1:0] MAXV = {{(PW-OW+1){1'b0}},
		{(OW-1){1'b1}}};
	localparam logic signed [PW-1:0] MINV = {{(PW-OW+1){1'b1}},
		{(OW-1){1'b0}}};

	logic signed [PW-1:0] prod;
	logic signed [PW-1:0] shifted;

	always_comb begin
		prod = a_i * b_i;
		shifted = prod >>> SH;
		if (shifted > MAXV) begin
			p_o = MAXV[OW-1:0];
		end else if (shifted < MINV) begin
			p_o = MINV[OW-1:0];
		end else begin
			p_o = shifted[OW-1:0];
		end
	end
endmodule

// ---- tb/hall_comp_linearizer_path_tb_top.sv ----
// Purpose: self-checking bench for hcl_comp_lin
// Assumes: unity fine gain
// Notes: breakpoints 128*j-1024 give slope two
`timescale 1ns/100ps
module hall_comp_linearizer_path_tb_top;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic req = 1'b0;
	logic signed [15:0] val = '0;
	logic signed [8:0] dt = '0;
	logic [4:0] reg_addr_i = '0;
	logic [23:0] reg_wdata_i = '0;
	logic reg_we_i = 1'b0;
	logic reg_re_i = 1'b0;
	wire logic signed [15:0] sample_i;
	wire logic signed [8:0] temp_delta_i;
	wire logic sample_valid_i, sample_ready_o, comp_valid_o, lin_valid_o, busy_o;
	wire logic [23:0] reg_rdata_o;
	wire logic signed [12:0] comp_o, lin_o;
	logic [23:0] mk [5] = '{24'h00f7ff, 24'h7ff7ff, 24'h3ff3ff, 24'h00ffff,
		24'hffffff};
	int bad_count = 0;
	int checks = 0;
	int cyc = 0;
	always #5 clk_sys_i = ~clk_sys_i;
	hcl_front_end fe (.clk_sys_i, .rst_n_i, .req_i(req), .val_i(val),
		.dt_i(dt), .ready_i(sample_ready_o), .sample_o(sample_i),
		.temp_o(temp_delta_i), .valid_o(sample_valid_i));
	hcl_comp_lin uut (.clk_sys_i, .rst_n_i, .sample_i, .temp_delta_i,
		.sample_valid_i, .sample_ready_o, .reg_addr_i, .reg_wdata_i,
		.reg_we_i, .reg_re_i, .reg_rdata_o, .comp_o, .comp_valid_o, .lin_o,
		.lin_valid_o, .busy_o);
	task automatic final_report();
		$display("checks %0d errors %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(logic [23:0] seen, logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic int sat(int v, int lo, int hi);
		return v < lo ? lo : v > hi ? hi : v;
	endfunction
	task automatic wr(logic [4:0] a, logic [23:0] d);
		@(posedge clk_sys_i);
		reg_we_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_sys_i);
		reg_we_i <= 1'b0;
	endtask
	task automatic rd(logic [4:0] a, logic [23:0] m, logic [23:0] e);
		@(posedge clk_sys_i);
		reg_re_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_sys_i);
		reg_re_i <= 1'b0;
		#1 chk(reg_rdata_o & m, e & m);
	endtask
	task automatic run(int m, int s, int d, int c);
		int x, y, n;
		x = m[3] ? sat(-c, -4096, 4095) : c;
		if (!m[0])
			y = x;
		else if (m[1])
			y = x < -1024 ? -2304 : x >= 1024 ? 2048 : 256 * ((x + 1024) / 128) - 2048;
		else
			y = sat(2 * x, -2304, 2304);
		if (m[2])
			y = sat(-y, -4096, 4095);
		@(posedge clk_sys_i);
		req <= 1'b1;
		val <= 16'(s);
		dt <= 9'(d);
		@(posedge clk_sys_i);
		req <= 1'b0;
		for (n = 0; n < 40 && lin_valid_o !== 1'b1; n++) @(posedge clk_sys_i) #1;
		chk(24'(n < 40), 24'h1);
		chk(24'(comp_o), 24'(c));
		chk(24'(lin_o), 24'(y));
		rd(hcl_pkg::ADDR_RESULT, 24'hffffff, {11'h000, 13'(y)});
		rd(hcl_pkg::ADDR_STATUS, 24'hffffff, {11'h000, 13'(c)});
	endtask
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end
	initial begin
		int s, d, co, pol, qo, qh, qc, c, w, t1, t2, f;
		void'($urandom(32'h2abadcbf));
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		for (int a = 3; a < 8; a++) rd(5'(a), 24'hffffff, 24'h0);
		for (int a = 3; a < 8; a++) begin
			w = $urandom;
			wr(5'(a), 24'(w));
			rd(5'(a), mk[a - 3], 24'(w));
		end
		wr(5'h1f, 24'hffffff);
		rd(5'h1f, 24'hffffff, 24'h0);
		for (int k = 0; k < 8; k++)
			wr(hcl_pkg::ADDR_LIN_FIRST + 5'(k), {12'(256 * k - 896), 12'(256 * k - 1024)});
		for (int i = 0; i < 64; i++) begin
			pol = $urandom_range(0, 1);
			co = $urandom_range(0, 5);
			qo = $urandom_range(0, 400) - 200;
			qh = $urandom_range(0, 4095) - 2048;
			qc = $urandom_range(0, 4095) - 2048;
			d = $urandom_range(0, 190) - 65;
			s = $urandom_range(0, 3000) - 1500;
			s = s >>> co;
			t1 = $urandom;
			t2 = $urandom;
			wr(hcl_pkg::ADDR_GAIN_TC1, 24'(t1));
			wr(hcl_pkg::ADDR_GAIN_TC2, 24'(t2));
			wr(hcl_pkg::ADDR_GAIN_TRIM, {8'h0, 1'(pol), 3'(co), 1'b0, 11'h400});
			wr(hcl_pkg::ADDR_QO_TRIM, {8'h0, 16'(qo)});
			wr(hcl_pkg::ADDR_QO_TC, {12'(qc), 12'(qh)});
			wr(hcl_pkg::ADDR_LIN_CTRL, {8'h0, 4'(i % 16), 12'h400});
			f = d >= 0 ? int'(signed'(t1[10:0])) * d * 128 +
				int'(signed'(t2[9:0])) * d * d :
				int'(signed'(t1[22:12])) * d * 256 +
				int'(signed'(t2[21:12])) * d * d * 4;
			c = sat(int'(longint'((pol ? -s : s) <<< co) *
				(f + hcl_pkg::FAC_ONE) >>> hcl_pkg::FAC_FRAC), -65536, 65535);
			c = sat(c + qo + (d >= 0 ? (qh * d) >>> 6 : (qc * d) >>> 5), -4096, 4095);
			run(i % 16, s, d, c);
		end
		final_report();
	end
endmodule
bind hcl_comp_lin hcl_comp_lin_asserts chk_i (.clk_sys_i, .rst_n_i,
	.sample_valid_i, .sample_ready_o, .reg_re_i, .reg_rdata_o, .comp_o,
	.comp_valid_o, .lin_o, .lin_valid_o, .busy_o);

// ---- tb/hcl_comp_lin_asserts.sv ----
// Purpose: port timing checks for hcl_comp_lin
// Assumes: one sample in flight
// Notes: bound from the bench top
`timescale 1ns/100ps
module hcl_comp_lin_asserts (
	input wire logic clk_sys_i, // Clock
	input wire logic rst_n_i, // Reset
	input wire logic sample_valid_i, // Strobe
	input wire logic sample_ready_o, // Ready
	input wire logic reg_re_i, // Read strobe
	input wire logic [23:0] reg_rdata_o, // Read data
	input wire logic signed [12:0] comp_o, // Comp
	input wire logic comp_valid_o, // Comp pulse
	input wire logic signed [12:0] lin_o, // Lin
	input wire logic lin_valid_o, // Lin pulse
	input wire logic busy_o // Busy
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	wire logic take = sample_valid_i && sample_ready_o;
	AST_RD_IDLE: assert property (!$past(reg_re_i) |-> reg_rdata_o == '0)
		else $error("read data not cleared");
	AST_COMP_LAT: assert property (take |-> ##4 comp_valid_o)
		else $error("comp late");
	AST_COMP_SRC: assert property (comp_valid_o |-> $past(take, 4))
		else $error("comp without sample");
	AST_LIN_LAT: assert property (take |-> (##5 lin_valid_o) or (##28 lin_valid_o))
		else $error("lin late");
	AST_BUSY: assert property (take |=> busy_o [*4])
		else $error("busy dropped");
	AST_READY: assert property (sample_ready_o == !busy_o)
		else $error("ready mismatch");
	AST_COMP_HOLD: assert property (!comp_valid_o |-> $stable(comp_o))
		else $error("comp moved");
	AST_LIN_HOLD: assert property (!lin_valid_o |-> $stable(lin_o))
		else $error("lin moved");
	AST_LIN_DONE: assert property (lin_valid_o |-> sample_ready_o && !comp_valid_o)
		else $error("lin not last");
endmodule

// ---- tb/hcl_front_end.sv ----
// Purpose: front-end sample source
// Assumes: one request at a time
// Notes: lines toggle once taken, never show stale data
`timescale 1ns/100ps
module hcl_front_end (
	input wire logic clk_sys_i, // Clock
	input wire logic rst_n_i, // Reset
	input wire logic req_i, // Send one sample
	input wire logic signed [15:0] val_i, // Sample value
	input wire logic signed [8:0] dt_i, // Temperature delta
	input wire logic ready_i, // Path ready
	output logic signed [15:0] sample_o, // To path
	output logic signed [8:0] temp_o, // To path
	output logic valid_o // Strobe
);
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			valid_o <= 1'b0;
			sample_o <= '0;
			temp_o <= '0;
		end else if (req_i) begin
			valid_o <= 1'b1;
			sample_o <= val_i;
			temp_o <= dt_i;
		end else if (valid_o && ready_i) begin
			valid_o <= 1'b0;
			sample_o <= ~sample_o;
			temp_o <= ~temp_o;
		end
	end
endmodule
